// ### inc/sdg_pkg.sv
/*
 * sdg_pkg: offsets, field positions, reset values and carrier types of the
 * socket detect / shared global control block.
 * assumes: byte-wide registers at byte offsets within one socket's space.
 */
`default_nettype none

package sdg_pkg;

    // ================
    // sizes
    // ================
    localparam int          SDG_SOCKETS        = 2;
    localparam int          SDG_ADDR_W         = 12;
    localparam int          SDG_SYNC_STAGES    = 2;
    localparam logic [1:0]  SDG_SETTLE_CYCLES  = 2'h3;

    // ================
    // register offsets (byte addresses inside a socket's space)
    // ================
    localparam logic [11:0] SDG_OFS_STATUS_CHANGE  = 12'h804;
    localparam logic [11:0] SDG_OFS_DETECT_CONTROL = 12'h816;
    localparam logic [11:0] SDG_OFS_GLOBAL_CONTROL = 12'h81e;

    // ================
    // socket_detect_control fields
    // ================
    localparam int SDG_DET_SENSE_TWO_BIT   = 7;
    localparam int SDG_DET_SENSE_ONE_BIT   = 6;
    localparam int SDG_DET_SOFT_TRIG_BIT   = 5;
    localparam int SDG_DET_WAKE_EN_BIT     = 4;
    localparam int SDG_DET_CLR_REMOVE_BIT  = 1;
    localparam logic SDG_DET_WAKE_EN_RESET    = 1'b0;
    localparam logic SDG_DET_CLR_REMOVE_RESET = 1'b0;

    // ================
    // shared_global_control fields
    // ================
    localparam int SDG_GLB_B_IRQ_BIT       = 4;
    localparam int SDG_GLB_A_IRQ_BIT       = 3;
    localparam int SDG_GLB_FLAG_CLR_BIT    = 2;
    localparam int SDG_GLB_CHG_IRQ_BIT     = 1;
    localparam int SDG_GLB_FLOAT_BIT       = 0;
    localparam logic [4:0] SDG_GLB_RESET   = 5'h00;

    // status_change_register: card-detect change flag
    localparam int SDG_CSC_DETECT_BIT      = 0;
    localparam logic SDG_CSC_RESET         = 1'b0;

    // ================
    // carriers
    // ================
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic                  sock;
        logic [SDG_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
    } sdg_bus_req_type;

    typedef struct packed {
        logic card_present_pin_one;
        logic card_present_pin_two;
        logic voltage_sense_pin_one;
        logic voltage_sense_pin_two;
    } sdg_card_pins_type;

endpackage : sdg_pkg

`default_nettype wire

// ### design/sdg_pin_sync.sv
/*
 * sdg_pin_sync: two-flop synchroniser for a bundle of pin levels.
 * assumes: inputs are quasi-static levels; no bus coherency is implied.
 */
`default_nettype none

module sdg_pin_sync
    import sdg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    // pins and their synchronised copy
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    // the first stage feeds only the second stage
    always_comb begin
        meta_next   = async_i;
        stable_next = meta_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta_reg   <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg   <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign sync_o = stable_reg;

endmodule : sdg_pin_sync

`default_nettype wire

// ### design/sdg_irq_signal.sv
/*
 * sdg_irq_signal: edge or level host interrupt signalling per channel.
 * assumes: cond_i is a level on the same clock; mode 0 edge, 1 level.
 */
`default_nettype none

module sdg_irq_signal
    import sdg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    // condition and mode
    input  wire logic [WIDTH-1:0] cond_i,
    input  wire logic [WIDTH-1:0] level_mode_i,
    // host interrupt
    output logic      [WIDTH-1:0] irq_o
);

    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;
    logic [WIDTH-1:0] irq_reg;
    logic [WIDTH-1:0] irq_next;

    // edge mode gives one pulse per rising condition, level mode follows it
    always_comb begin
        prev_next = cond_i;
        irq_next  = (level_mode_i & cond_i) | (~level_mode_i & cond_i & ~prev_reg);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prev_reg <= '0;
            irq_reg  <= '0;
        end else begin
            prev_reg <= prev_next;
            irq_reg  <= irq_next;
        end
    end

    assign irq_o = irq_reg;

endmodule : sdg_irq_signal

`default_nettype wire

// ### design/sdg_socket_detect_global_ctrl.sv
/*
 * sdg_socket_detect_global_ctrl: per-socket detect/control registers, the
 * shared global control register and the card-detect change flag of two
 * card sockets, with wake, removal reset, float control and host interrupts.
 * assumes: host byte accesses are one-cycle strobes on ref_clk_i; card pins
 * are asynchronous; the detect-change interrupt enable comes from the
 * neighbouring status-change interrupt configuration register.
 */
// Summary of operation
// - bit 7 of detect control reads the live second voltage-sense pin level
// - bit 6 of detect control reads the live first voltage-sense pin level
// - writing 1 to bit 5 with change enable set raises a detect change
// - writing 1 to bit 5 with change enable clear does nothing at all
// - bit 5 always reads back as zero
// - with wake enable set, any card-detect pin change pulls ring wake low
// - ring wake stays low until the detect change flag is cleared
// - wake enable clear disables wake signalling; it resets to zero
// - clear-on-removal set resets socket registers when the card leaves
// - detect control bits 3, 2 and 0 read as zero
// - one global register, shared, visible at both sockets' offset
// - global bit 4 selects edge or level for socket B card interrupts
// - global bit 3 selects edge or level for socket A card interrupts
// - global bit 2 picks clear-on-read or write-one-to-clear for flags
// - global bit 1 selects edge or level for status change interrupts
// - global bit 0 floats card outputs except during an active card cycle
// - interrupts are still accepted while card outputs float
// - global bits 7 to 5 read zero; writable bits reset to zero
`default_nettype none

module sdg_socket_detect_global_ctrl
    import sdg_pkg::*;
(
    // clock and reset
    input  wire logic                               ref_clk_i,
    input  wire logic                               sys_rst_i,
    // host register access
    input  wire sdg_bus_req_type                    bus_req_i,
    output logic              [7:0]                 rd_data_o,
    output logic                                    rd_valid_o,
    // card pins, one set per socket (asynchronous)
    input  wire sdg_card_pins_type [SDG_SOCKETS-1:0] card_pins_i,
    input  wire logic         [SDG_SOCKETS-1:0]     card_irq_i,
    // neighbouring logic on the same clock
    input  wire logic         [SDG_SOCKETS-1:0]     detect_change_irq_enable_i,
    input  wire logic         [SDG_SOCKETS-1:0]     card_cycle_active_i,
    // outputs
    output logic                                    ring_wake_output_n_o,
    output logic              [SDG_SOCKETS-1:0]     card_out_en_o,
    output logic              [SDG_SOCKETS-1:0]     csc_irq_o,
    output logic              [SDG_SOCKETS-1:0]     card_irq_o,
    output logic              [SDG_SOCKETS-1:0]     card_regs_reset_o
);

    // ================
    // pin synchronisation
    // ================
    localparam int PIN_W = SDG_SOCKETS * 5;

    sdg_card_pins_type [SDG_SOCKETS-1:0] pins_sync;
    logic              [SDG_SOCKETS-1:0] card_irq_sync;

    sdg_pin_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({card_irq_i, card_pins_i}),
        .sync_o    ({card_irq_sync, pins_sync})
    );

    // ================
    // shared global control
    // ================
    logic [4:0] global_reg;
    logic [4:0] global_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic       settled;
    logic       wr_global;
    logic       flag_clear_method;
    logic       card_output_float_mode;

    // one register for both sockets: the socket select is ignored here
    assign wr_global = bus_req_i.wr && (bus_req_i.addr == SDG_OFS_GLOBAL_CONTROL);
    assign flag_clear_method      = global_reg[SDG_GLB_FLAG_CLR_BIT];
    assign card_output_float_mode = global_reg[SDG_GLB_FLOAT_BIT];
    assign settled                = (settle_reg == SDG_SETTLE_CYCLES);

    // the settle count masks detect edges until the synchroniser holds real levels
    always_comb begin
        global_next = global_reg;
        if (wr_global) begin
            global_next = bus_req_i.wdata[4:0];
        end
        settle_next = settled ? settle_reg : settle_reg + 2'h1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            global_reg <= SDG_GLB_RESET;
            settle_reg <= 2'h0;
        end else begin
            global_reg <= global_next;
            settle_reg <= settle_next;
        end
    end

    // ================
    // per-socket detect, flag, wake and output float logic
    // ================
    logic [SDG_SOCKETS-1:0] wake_en_reg;
    logic [SDG_SOCKETS-1:0] wake_en_next;
    logic [SDG_SOCKETS-1:0] clr_remove_reg;
    logic [SDG_SOCKETS-1:0] clr_remove_next;
    logic [SDG_SOCKETS-1:0] csc_flag_reg;
    logic [SDG_SOCKETS-1:0] csc_flag_next;
    logic [SDG_SOCKETS-1:0] wake_reg;
    logic [SDG_SOCKETS-1:0] wake_next;
    logic [SDG_SOCKETS-1:0] regs_reset_reg;
    logic [SDG_SOCKETS-1:0] regs_reset_next;
    logic [SDG_SOCKETS-1:0] out_en_reg;
    logic [SDG_SOCKETS-1:0] out_en_next;
    logic [1:0]             cd_prev_reg  [SDG_SOCKETS];
    logic [1:0]             cd_prev_next [SDG_SOCKETS];

    genvar s;
    generate
        for (s = 0; s < SDG_SOCKETS; s++) begin : g_sock
            logic       sel;
            logic       wr_detect;
            logic       wr_csc;
            logic       rd_csc;
            logic [1:0] cd_now;
            logic       cd_change;
            logic       removal;
            logic       soft_set;
            logic       flag_set;
            logic       flag_clear;

            assign sel       = (bus_req_i.sock == 1'(s));
            assign wr_detect = bus_req_i.wr && sel && (bus_req_i.addr == SDG_OFS_DETECT_CONTROL);
            assign wr_csc    = bus_req_i.wr && sel && (bus_req_i.addr == SDG_OFS_STATUS_CHANGE);
            assign rd_csc    = bus_req_i.rd && sel && (bus_req_i.addr == SDG_OFS_STATUS_CHANGE);
            assign cd_now    = {pins_sync[s].card_present_pin_two,
                                pins_sync[s].card_present_pin_one};
            // pins are active low: a card sits when both read low
            assign cd_change = settled && (cd_now != cd_prev_reg[s]);
            assign removal   = settled && (cd_prev_reg[s] == 2'h0) && (cd_now != 2'h0);
            // a software trigger without the change enable is simply dropped
            assign soft_set  = wr_detect && bus_req_i.wdata[SDG_DET_SOFT_TRIG_BIT]
                               && detect_change_irq_enable_i[s];
            assign flag_set  = soft_set || (cd_change && detect_change_irq_enable_i[s]);
            assign flag_clear = flag_clear_method
                                ? (wr_csc && bus_req_i.wdata[SDG_CSC_DETECT_BIT])
                                : rd_csc;

            // control bits, change flag and wake latch; flag and wake set beats clear, removal reset beats a control write
            always_comb begin
                wake_en_next[s]    = wake_en_reg[s];
                clr_remove_next[s] = clr_remove_reg[s];
                if (wr_detect) begin
                    wake_en_next[s]    = bus_req_i.wdata[SDG_DET_WAKE_EN_BIT];
                    clr_remove_next[s] = bus_req_i.wdata[SDG_DET_CLR_REMOVE_BIT];
                end
                if (removal && clr_remove_reg[s]) begin
                    wake_en_next[s]    = SDG_DET_WAKE_EN_RESET;
                    clr_remove_next[s] = SDG_DET_CLR_REMOVE_RESET;
                end
                regs_reset_next[s] = removal && clr_remove_reg[s];
                csc_flag_next[s]   = flag_set ? 1'b1
                                   : (flag_clear ? 1'b0 : csc_flag_reg[s]);
                // only a real pin change wakes, never the software trigger
                if (cd_change && wake_en_reg[s]) begin
                    wake_next[s] = 1'b1;
                end else if (flag_clear) begin
                    wake_next[s] = 1'b0;
                end else begin
                    wake_next[s] = wake_reg[s];
                end
                cd_prev_next[s] = cd_now;
                // outputs float in power-down unless a card cycle is running
                out_en_next[s]  = !card_output_float_mode || card_cycle_active_i[s];
            end

            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    wake_en_reg[s]    <= SDG_DET_WAKE_EN_RESET;
                    clr_remove_reg[s] <= SDG_DET_CLR_REMOVE_RESET;
                    csc_flag_reg[s]   <= SDG_CSC_RESET;
                    wake_reg[s]       <= 1'b0;
                    regs_reset_reg[s] <= 1'b0;
                    out_en_reg[s]     <= 1'b1;
                    cd_prev_reg[s]    <= 2'h0;
                end else begin
                    wake_en_reg[s]    <= wake_en_next[s];
                    clr_remove_reg[s] <= clr_remove_next[s];
                    csc_flag_reg[s]   <= csc_flag_next[s];
                    wake_reg[s]       <= wake_next[s];
                    regs_reset_reg[s] <= regs_reset_next[s];
                    out_en_reg[s]     <= out_en_next[s];
                    cd_prev_reg[s]    <= cd_prev_next[s];
                end
            end
        end
    endgenerate

    // ================
    // ring wake pin, shared by both sockets
    // ================
    logic ring_wake_n_reg;
    logic ring_wake_n_next;

    always_comb begin
        ring_wake_n_next = ~(|wake_reg);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ring_wake_n_reg <= 1'b1;
        end else begin
            ring_wake_n_reg <= ring_wake_n_next;
        end
    end

    // ================
    // host interrupts: never gated by power-down
    // ================
    sdg_irq_signal #(
        .WIDTH (SDG_SOCKETS)
    ) u_csc_irq (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .cond_i       (csc_flag_reg),
        .level_mode_i ({SDG_SOCKETS{global_reg[SDG_GLB_CHG_IRQ_BIT]}}),
        .irq_o        (csc_irq_o)
    );

    sdg_irq_signal #(
        .WIDTH (SDG_SOCKETS)
    ) u_card_irq (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .cond_i       (card_irq_sync),
        .level_mode_i ({global_reg[SDG_GLB_B_IRQ_BIT], global_reg[SDG_GLB_A_IRQ_BIT]}),
        .irq_o        (card_irq_o)
    );

    // ================
    // read path: registered, one cycle after the strobe
    // ================
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       rd_valid_reg;
    logic       rd_valid_next;

    // unmapped offsets answer zero so software never sees stale data
    always_comb begin
        rd_data_next  = 8'h00;
        rd_valid_next = bus_req_i.rd;
        if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                SDG_OFS_DETECT_CONTROL: begin
                    rd_data_next[SDG_DET_SENSE_TWO_BIT] =
                        pins_sync[bus_req_i.sock].voltage_sense_pin_two;
                    rd_data_next[SDG_DET_SENSE_ONE_BIT] =
                        pins_sync[bus_req_i.sock].voltage_sense_pin_one;
                    rd_data_next[SDG_DET_SOFT_TRIG_BIT] = 1'b0;
                    rd_data_next[SDG_DET_WAKE_EN_BIT]    = wake_en_reg[bus_req_i.sock];
                    rd_data_next[SDG_DET_CLR_REMOVE_BIT] = clr_remove_reg[bus_req_i.sock];
                end
                SDG_OFS_GLOBAL_CONTROL: begin
                    rd_data_next = {3'h0, global_reg};
                end
                SDG_OFS_STATUS_CHANGE: begin
                    rd_data_next[SDG_CSC_DETECT_BIT] = csc_flag_reg[bus_req_i.sock];
                end
                default: begin
                    rd_data_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // ================
    // output drive
    // ================
    assign rd_data_o            = rd_data_reg;
    assign rd_valid_o           = rd_valid_reg;
    assign ring_wake_output_n_o = ring_wake_n_reg;
    assign card_out_en_o        = out_en_reg;
    assign card_regs_reset_o    = regs_reset_reg;

endmodule : sdg_socket_detect_global_ctrl

`default_nettype wire

// ### sim/sdg_card_model.sv
/* sdg_card_model: the cards seated in the two sockets, as seen at the pins.
   assumes: the bench sets present_i (1 = seated) and two sense levels a socket. */
`default_nettype none
module sdg_card_model
    import sdg_pkg::*;
(
    // clock
    input  wire logic               ref_clk_i,
    // seated cards and sense levels, {two, one} per socket
    input  wire logic [1:0]         present_i,
    input  wire logic [3:0]         sense_i,
    // socket pins
    output var sdg_card_pins_type [1:0] card_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // contacts
    // ========================================================================
    // empty socket: pull-ups win, so all pins read high
    initial card_pins_o = '1;
    // pin two lags pin one by a cycle: a card never makes both contacts at once
    always @(posedge ref_clk_i) begin
        for (int k = 0; k < 2; k++) begin
            card_pins_o[k].card_present_pin_one  <= !present_i[k];
            card_pins_o[k].card_present_pin_two  <= card_pins_o[k].card_present_pin_one;
            card_pins_o[k].voltage_sense_pin_one <= sense_i[2*k];
            card_pins_o[k].voltage_sense_pin_two <= sense_i[2*k+1];
        end
    end
endmodule : sdg_card_model
`default_nettype wire

// ### sim/sdg_socket_detect_global_ctrl_chk.sv
/* sdg_socket_detect_global_ctrl_chk: port-level assertions of the control block.
   assumes: bound to the top module; every port on ref_clk_i. */
`default_nettype none
module sdg_socket_detect_global_ctrl_chk
    import sdg_pkg::*;
(
    // clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    // host side
    input  wire sdg_bus_req_type        bus_req_i,
    input  wire logic [7:0]             rd_data_o,
    input  wire logic                   rd_valid_o,
    // card side and interrupts
    input  wire logic [SDG_SOCKETS-1:0] card_cycle_active_i,
    input  wire logic                   ring_wake_output_n_o,
    input  wire logic [SDG_SOCKETS-1:0] card_out_en_o,
    input  wire logic [SDG_SOCKETS-1:0] csc_irq_o,
    input  wire logic [SDG_SOCKETS-1:0] card_irq_o,
    input  wire logic [SDG_SOCKETS-1:0] card_regs_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // assertions
    // ========================================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // read decodes of the two registers
    wire logic rd_det = bus_req_i.rd && bus_req_i.addr == SDG_OFS_DETECT_CONTROL;
    wire logic rd_glb = bus_req_i.rd && bus_req_i.addr == SDG_OFS_GLOBAL_CONTROL;
    a_read_answer: assert property (bus_req_i.rd |=> rd_valid_o)
        else $error("read not answered");
    a_idle_quiet: assert property (!bus_req_i.rd |=> !rd_valid_o && rd_data_o == 8'h00)
        else $error("read data without a read");
    a_detect_zeros: assert property (rd_det |=> (rd_data_o & 8'h2d) == 8'h00)
        else $error("detect control zero bits set");
    a_global_zeros: assert property (rd_glb |=> rd_data_o[7:5] == 3'h0)
        else $error("global control high bits set");
    a_cycle_drives: assert property ((~card_out_en_o & $past(card_cycle_active_i)) == 2'h0)
        else $error("outputs floated during a card cycle");
    a_wake_holds: assert property (!ring_wake_output_n_o && !bus_req_i.wr && !bus_req_i.rd
        && !$past(bus_req_i.wr) && !$past(bus_req_i.rd) |=> !ring_wake_output_n_o)
        else $error("wake released without a clear");
    a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=> ring_wake_output_n_o
        && card_out_en_o == 2'h3 && (csc_irq_o | card_irq_o | card_regs_reset_o) == 2'h0)
        else $error("outputs not at reset values");
    a_remove_pulse: assert property (card_regs_reset_o != 2'h0 |=> card_regs_reset_o == 2'h0)
        else $error("removal reset longer than a cycle");
    // main scenarios reached
    c_read: cover property (rd_valid_o);
    c_wake: cover property ($fell(ring_wake_output_n_o));
    c_remove: cover property (card_regs_reset_o != 2'h0);
endmodule : sdg_socket_detect_global_ctrl_chk
`default_nettype wire

// ### sim/test_socket_detect_global_ctrl.sv
/* test_socket_detect_global_ctrl: directed bench for the control block.
   assumes: card model on the pins; bench plays host and neighbouring logic. */
`default_nettype none
module test_socket_detect_global_ctrl
    import sdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ================
    // signals
    // ================
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1;
    sdg_bus_req_type bus_req_i = '0;
    sdg_card_pins_type [1:0] card_pins_i;
    logic [1:0] card_irq_i = 2'h0, detect_change_irq_enable_i = 2'h0, present = 2'h3;
    logic [1:0] card_cycle_active_i = 2'h0, card_out_en_o, csc_irq_o, card_irq_o, card_regs_reset_o;
    logic [3:0] sense = 4'h0;
    logic [7:0] rd_data_o, d;
    logic rd_valid_o, ring_wake_output_n_o;
    int miscompares = 0, n_compared = 0;
    localparam logic [11:0] STATUS_CHANGE_REGISTER = SDG_OFS_STATUS_CHANGE, DET = SDG_OFS_DETECT_CONTROL;
    localparam logic [11:0] GLB = SDG_OFS_GLOBAL_CONTROL;
    always #25 ref_clk_i = !ref_clk_i;
    sdg_card_model u_card (.ref_clk_i, .present_i(present), .sense_i(sense), .card_pins_o(card_pins_i));
    sdg_socket_detect_global_ctrl u_dut (.ref_clk_i, .sys_rst_i, .bus_req_i, .rd_data_o,
        .rd_valid_o, .card_pins_i, .card_irq_i, .detect_change_irq_enable_i,
        .card_cycle_active_i, .ring_wake_output_n_o, .card_out_en_o, .csc_irq_o, .card_irq_o,
        .card_regs_reset_o);
    // ================
    // host cycles and checks
    // ================
    task automatic bw(input logic s, input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk_i) bus_req_i <= '{1'b1, 1'b0, s, a, v};
        @(posedge ref_clk_i) bus_req_i <= '0;
    endtask : bw
    // read data is taken in the cycle after the strobe, its only valid cycle
    task automatic br(input logic s, input logic [11:0] a);
        @(posedge ref_clk_i) bus_req_i <= '{1'b0, 1'b1, s, a, 8'h00};
        @(posedge ref_clk_i) bus_req_i <= '0;
        #1 d = rd_data_o;
    endtask : br
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    wire logic [4:0] obs = {card_regs_reset_o[1], card_irq_o, csc_irq_o[0], ring_wake_output_n_o};
    // bounded wait; a miss ends the run
    task automatic wt(input int sel, input logic v, input string n);
        for (int i = 0; i < 12 && obs[sel] !== v; i++) @(posedge ref_clk_i) #1;
        chk(n, {7'h0, v}, {7'h0, obs[sel]});
        if (obs[sel] !== v) print_verdict();
    endtask : wt
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i) #1;
    endtask : cyc
    // ================
    // scenarios
    // ================
    task automatic t_regs();
        br(0, GLB); chk("glb_rst", 8'h00, d);
        br(1, DET); chk("det_rst", 8'h00, d & 8'h3f);
        bw(0, GLB, 8'hff); br(1, GLB); chk("glb_shared", 8'h1f, d);
        bw(1, GLB, 8'h00); bw(0, DET, 8'hff);
        br(0, DET); chk("det_bits", 8'h12, d & 8'h3f);
        br(1, DET); chk("det_other", 8'h00, d & 8'h3f);
        bw(0, DET, 8'h00);
        for (int k = 0; k < 4; k++) begin
            sense <= {~k[1:0], k[1:0]};
            cyc(5);
            br(0, DET); chk("sense_a", {k[1:0], 6'h0}, d & 8'hc0);
            br(1, DET); chk("sense_b", {~k[1:0], 6'h0}, d & 8'hc0);
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_soft();
        bw(0, DET, 8'h20); cyc(4);
        br(0, STATUS_CHANGE_REGISTER); chk("soft_off", 8'h00, d);
        detect_change_irq_enable_i <= 2'h3;
        bw(0, DET, 8'h20); wt(1, 1'b1, "csc_edge");
        cyc(1); chk("csc_pulse", 8'h00, {7'h0, csc_irq_o[0]});
        br(0, STATUS_CHANGE_REGISTER); chk("flag_set", 8'h01, d);
        br(0, STATUS_CHANGE_REGISTER); chk("flag_rdclr", 8'h00, d);
        bw(0, GLB, 8'h06); bw(0, DET, 8'h20); wt(1, 1'b1, "csc_level");
        cyc(4); chk("csc_hold", 8'h01, {7'h0, csc_irq_o[0]});
        br(0, STATUS_CHANGE_REGISTER); br(0, STATUS_CHANGE_REGISTER); chk("flag_w1c", 8'h01, d);
        bw(0, STATUS_CHANGE_REGISTER, 8'h01); wt(1, 1'b0, "csc_clear");
        bw(0, GLB, 8'h00);
        $display("t_soft done");
    endtask : t_soft
    task automatic t_wake();
        bw(0, DET, 8'h10); present <= 2'h2; wt(0, 1'b0, "wake_low");
        cyc(5); chk("wake_hold", 8'h00, {7'h0, ring_wake_output_n_o});
        br(0, STATUS_CHANGE_REGISTER); wt(0, 1'b1, "wake_clear");
        bw(0, DET, 8'h00); present <= 2'h3; cyc(8);
        chk("wake_off", 8'h01, {7'h0, ring_wake_output_n_o});
        br(0, STATUS_CHANGE_REGISTER);
        bw(1, DET, 8'h02); present <= 2'h1; wt(4, 1'b1, "remove_rst");
        br(1, DET); chk("remove_regs", 8'h00, d & 8'h3f);
        present <= 2'h3; cyc(8); br(1, STATUS_CHANGE_REGISTER);
        $display("t_wake done");
    endtask : t_wake
    task automatic t_float();
        bw(0, GLB, 8'h11); cyc(2);
        chk("float", 8'h00, {6'h0, card_out_en_o});
        card_cycle_active_i <= 2'h1; cyc(2);
        chk("cycle_on", 8'h01, {6'h0, card_out_en_o});
        card_cycle_active_i <= 2'h0; cyc(2);
        chk("cycle_off", 8'h00, {6'h0, card_out_en_o});
        card_irq_i <= 2'h3; wt(2, 1'b1, "irq_a");
        cyc(1); chk("irq_a_edge", 8'h00, {7'h0, card_irq_o[0]});
        cyc(3); chk("irq_b_level", 8'h01, {7'h0, card_irq_o[1]});
        card_irq_i <= 2'h0; wt(3, 1'b0, "irq_b_drop");
        bw(0, GLB, 8'h08); card_irq_i <= 2'h1; cyc(6);
        chk("irq_a_level", 8'h01, {7'h0, card_irq_o[0]});
        $display("t_float done");
    endtask : t_float
    // ================
    // run and verdict
    // ================
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        cyc(8);
        t_regs();
        t_soft();
        t_wake();
        t_float();
        print_verdict();
    end
endmodule : test_socket_detect_global_ctrl
bind sdg_socket_detect_global_ctrl sdg_socket_detect_global_ctrl_chk u_chk (.ref_clk_i,
    .sys_rst_i, .bus_req_i, .rd_data_o, .rd_valid_o, .card_cycle_active_i,
    .ring_wake_output_n_o, .card_out_en_o, .csc_irq_o, .card_irq_o, .card_regs_reset_o);
`default_nettype wire
